// File: src/qec_pkg.sv
// shared constants and types for the quadrature counter block
package qec_pkg;
	// channel count and counter width
	localparam int CH_NUM = 4;
	localparam int CNT_W = 24;
	// register word index, byte address is four times the index
	localparam logic [3:0] IDX_COUNT0 = 4'h0;
	localparam logic [3:0] IDX_CTRL = 4'h4;
	localparam logic [3:0] IDX_FLAG = 4'h5;
	localparam logic [3:0] IDX_IRQ_STAT = 4'h6;
	localparam logic [3:0] IDX_IRQ_MASK = 4'h7;
	localparam logic [3:0] IDX_INFO = 4'h8;
	// control field position and reset value
	localparam int CTRL_DIR_BIT = 0;
	localparam logic CTRL_DIR_RST = 1'b0;
	// info field positions
	localparam int INFO_ADDR_LSB = 0;
	localparam int INFO_SW_LSB = 4;
	localparam int INFO_REF_LSB = 8;
	// step size and zero values
	localparam logic [23:0] CNT_ONE = 24'h00_0001;
	localparam logic [23:0] CNT_ZERO = 24'h00_0000;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// pin inputs as sampled by the synchroniser
	typedef struct packed {
		logic [3:0] enc_a; // track a
		logic [3:0] enc_b; // track b
		logic [3:0] index; // index track
		logic [3:0] refer; // reference input
		logic [3:0] rst_sw_n; // reset enable switches, low enables
		logic [3:0] addr; // module address selector
	} pin_type;

	// whole state of the counter block
	typedef struct packed {
		pin_type sync1; // first synchroniser stage
		pin_type sync2; // second synchroniser stage
		logic [3:0] prev_a; // track a one cycle ago
		logic [3:0] prev_b; // track b one cycle ago
		logic [3:0][23:0] count; // signed counts
		logic [3:0] flag; // sticky reset flags, cleared by query
		logic [3:0] irq_stat; // sticky interrupt status
		logic [3:0] irq_mask; // interrupt mask
		logic dir_inv; // count direction inversion
		logic ack; // bus answer cycle
		logic [31:0] rdata; // read data
	} state_type;
endpackage : qec_pkg

// File: src/quad_encoder_counter.sv
// four-channel quadrature encoder counter with avalon-mm registers
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns

// What this block does
// - four channels, each a 24-bit counter
// - count up or down from track phase
// - clear count on reference and index together
// - reference clear enabled when switch off
// - count reads as signed 24-bit value
// - direction bit one inverts counting
// - sticky reset flag, cleared by each query, a new clear in the same cycle wins
// - module address from 4-bit selector
// - index and reference indicator outputs
module quad_encoder_counter
	import qec_pkg::*;
(
	input wire logic clock_in, // 50 mhz clock
	input wire logic nrst_in, // synchronous reset, low active
	input wire logic [5:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic [3:0] avs_byteenable_in, // byte lanes
	output logic [31:0] avs_readdata_out, // read data
	output logic avs_waitrequest_out, // stall
	input wire logic [3:0] enc_a_in, // encoder track a
	input wire logic [3:0] enc_b_in, // encoder track b
	input wire logic [3:0] enc_index_in, // encoder index track
	input wire logic [3:0] ref_in, // reference initiator
	input wire logic [3:0] nreference_reset_enable_in, // switch, low enables
	input wire logic [3:0] address_selector_in, // rotary selector
	output logic [3:0] address_out, // module address
	output logic [3:0] index_led_out, // index activity indicator
	output logic [3:0] ref_led_out, // reference level indicator
	output logic irq_out // level interrupt
);

	state_type s_r; // registered state
	state_type s_nxt; // next state
	pin_type pins; // raw pin bundle
	logic [3:0] step_c; // valid single step this cycle
	logic [3:0] up_c; // step direction is up
	logic [3:0] clr_c; // reference clear this cycle
	logic [3:0] widx; // word index of request
	logic done_c; // request completes this edge
	logic [23:0] cnt_sel_c; // count word addressed by the bus
	logic flag_query_c; // flag query completes this edge

	// gather pins into one bundle
	assign pins = '{enc_a: enc_a_in, enc_b: enc_b_in, index: enc_index_in,
		refer: ref_in, rst_sw_n: nreference_reset_enable_in, addr: address_selector_in};
	assign widx = avs_address_in[5:2];
	// count word under the bus address, used by the read checks
	assign cnt_sel_c = s_r.count[widx[1:0]];
	// a completed read of the flag word is a query
	assign flag_query_c = done_c & avs_read_in & (widx == IDX_FLAG);

	// next state of the whole block
	always_comb begin
		s_nxt = s_r;
		step_c = '0;
		up_c = '0;
		clr_c = '0;
		done_c = (avs_read_in | avs_write_in) & s_r.ack;
		s_nxt.sync1 = pins;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev_a = s_r.sync2.enc_a;
		s_nxt.prev_b = s_r.sync2.enc_b;
		// one wait cycle, then the answer
		s_nxt.ack = (avs_read_in | avs_write_in) & ~s_r.ack;
		for (int i = 0; i < CH_NUM; i++) begin
			step_c[i] = (s_r.sync2.enc_a[i] ^ s_r.prev_a[i]) ^ (s_r.sync2.enc_b[i] ^ s_r.prev_b[i]);
			up_c[i] = s_r.prev_a[i] ^ s_r.sync2.enc_b[i] ^ s_r.dir_inv;
			clr_c[i] = ~s_r.sync2.rst_sw_n[i] & s_r.sync2.refer[i] & s_r.sync2.index[i];
			if (clr_c[i]) begin
				s_nxt.count[i] = CNT_ZERO;
			end else if (step_c[i]) begin
				s_nxt.count[i] = up_c[i] ? s_r.count[i] + CNT_ONE : s_r.count[i] - CNT_ONE;
			end
		end
		// capture read data in the wait cycle
		if (avs_read_in & ~s_r.ack) begin
			s_nxt.rdata = RD_ZERO;
			unique case (widx)
				4'h0, 4'h1, 4'h2, 4'h3: begin
					// two's complement count in low bits
					s_nxt.rdata[23:0] = s_r.count[widx[1:0]];
				end
				IDX_CTRL: begin
					s_nxt.rdata[CTRL_DIR_BIT] = s_r.dir_inv;
				end
				IDX_FLAG: begin
					s_nxt.rdata[3:0] = s_r.flag;
				end
				IDX_IRQ_STAT: begin
					s_nxt.rdata[3:0] = s_r.irq_stat;
				end
				IDX_IRQ_MASK: begin
					s_nxt.rdata[3:0] = s_r.irq_mask;
				end
				IDX_INFO: begin
					s_nxt.rdata[INFO_ADDR_LSB +: 4] = s_r.sync2.addr;
					s_nxt.rdata[INFO_SW_LSB +: 4] = s_r.sync2.rst_sw_n;
					s_nxt.rdata[INFO_REF_LSB +: 4] = s_r.sync2.refer;
				end
				default: begin
					// unmapped reads as zero
					s_nxt.rdata = RD_ZERO;
				end
			endcase
		end
		if (done_c & avs_read_in & (widx == IDX_FLAG)) begin
			s_nxt.flag = '0;
		end
		// writes take effect on the answer edge
		if (done_c & avs_write_in & avs_byteenable_in[0]) begin
			if (widx == IDX_CTRL) begin
				s_nxt.dir_inv = avs_writedata_in[CTRL_DIR_BIT];
			end
			if (widx == IDX_IRQ_STAT) begin
				s_nxt.irq_stat = s_r.irq_stat & ~avs_writedata_in[3:0];
			end
			if (widx == IDX_IRQ_MASK) begin
				s_nxt.irq_mask = avs_writedata_in[3:0];
			end
		end
		// a new clear sets, and wins over the query
		s_nxt.flag = s_nxt.flag | clr_c;
		// set wins over write-one-to-clear
		s_nxt.irq_stat = s_nxt.irq_stat | clr_c;
	end

	// state register
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			s_r <= '0;
			s_r.dir_inv <= CTRL_DIR_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// bus, address and indicator outputs
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~s_r.ack;
	assign avs_readdata_out = s_r.rdata;
	assign address_out = s_r.sync2.addr;
	assign index_led_out = s_r.sync2.index;
	assign ref_led_out = s_r.sync2.refer;
	// interrupt when an unmasked bit is set
	assign irq_out = |(s_r.irq_stat & s_r.irq_mask);

	// bus answer within one wait cycle
	a_bus_answer: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(avs_read_in | avs_write_in) |-> ##[0:1] !avs_waitrequest_out)
		else $error("bus request not answered in time");

	a_addr_follow: assert property (@(posedge clock_in) disable iff (!nrst_in)
		$past(nrst_in, 3) |-> address_out == $past(address_selector_in, 2))
		else $error("address output does not follow selector");

	a_ref_led: assert property (@(posedge clock_in) disable iff (!nrst_in)
		$past(nrst_in, 3) |-> ref_led_out == $past(ref_in, 2))
		else $error("reference indicator wrong");

	a_dir_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(avs_write_in && !avs_waitrequest_out && widx == IDX_CTRL && avs_byteenable_in[0])
		|=> s_r.dir_inv == $past(avs_writedata_in[CTRL_DIR_BIT]))
		else $error("direction setting not stored");

	for (genvar g = 0; g < CH_NUM; g++) begin : g_chk
		a_ref_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
			clr_c[g] |=> s_r.count[g] == CNT_ZERO)
			else $error("count not cleared");
		a_sw_block: assert property (@(posedge clock_in) disable iff (!nrst_in)
			(s_r.sync2.rst_sw_n[g] && !step_c[g]) |=> $stable(s_r.count[g]))
			else $error("count changed with clear disabled");
		a_step_up: assert property (@(posedge clock_in) disable iff (!nrst_in)
			(step_c[g] && up_c[g] && !clr_c[g]) |=> s_r.count[g] == $past(s_r.count[g]) + CNT_ONE)
			else $error("up step wrong");
		a_wrap_max: assert property (@(posedge clock_in) disable iff (!nrst_in)
			(s_r.count[g] == 24'h7F_FFFF && step_c[g] && up_c[g] && !clr_c[g])
			|=> s_r.count[g] == 24'h80_0000)
			else $error("count does not wrap");
		// inversion turns a normal up step into a down step
		a_dir_inv: assert property (@(posedge clock_in) disable iff (!nrst_in)
			(step_c[g] && s_r.dir_inv && (s_r.prev_a[g] ^ s_r.sync2.enc_b[g]) && !clr_c[g])
			|=> s_r.count[g] == $past(s_r.count[g]) - CNT_ONE)
			else $error("direction not inverted");

		a_step_down: assert property (@(posedge clock_in) disable iff (!nrst_in)
			(step_c[g] && !up_c[g] && !clr_c[g]) |=> s_r.count[g] == $past(s_r.count[g]) - CNT_ONE)
			else $error("down step wrong");

		a_flag_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
			(s_r.flag[g] && !flag_query_c) |=> s_r.flag[g])
			else $error("reset flag dropped without query");

		// a clear raises the interrupt status
		a_irq_set: assert property (@(posedge clock_in) disable iff (!nrst_in)
			clr_c[g] |=> s_r.irq_stat[g])
			else $error("interrupt status not set by clear");
		a_double_skip: assert property (@(posedge clock_in) disable iff (!nrst_in)
			((s_r.sync2.enc_a[g] != s_r.prev_a[g]) && (s_r.sync2.enc_b[g] != s_r.prev_b[g])
			&& !clr_c[g]) |=> $stable(s_r.count[g]))
			else $error("double change counted");
		a_flag_set: assert property (@(posedge clock_in) disable iff (!nrst_in)
			clr_c[g] |=> s_r.flag[g] ##1 (s_r.flag[g] || $past(avs_read_in)))
			else $error("reset flag lost");
	end

	a_flag_query: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(done_c && avs_read_in && widx == IDX_FLAG && clr_c == '0) |=> s_r.flag == '0)
		else $error("flag not cleared by query");

	// index indicator follows the synchronised index
	a_index_led: assert property (@(posedge clock_in) disable iff (!nrst_in)
		$past(nrst_in, 3) |-> index_led_out == $past(enc_index_in, 2))
		else $error("index indicator wrong");

	// no stall while the bus is idle
	a_wait_idle: assert property (@(posedge clock_in) disable iff (!nrst_in)
		!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
		else $error("stall without request");

	// count read returns the count of the wait cycle
	a_read_count: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(done_c && avs_read_in && widx < IDX_CTRL) |-> avs_readdata_out[23:0] == $past(cnt_sel_c))
		else $error("count read data wrong");

	// upper bits of a count word read as zero
	a_read_high: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(done_c && avs_read_in && widx < IDX_CTRL) |-> avs_readdata_out[31:24] == 8'h00)
		else $error("count upper bits not zero");

	// mask write is stored on the answer edge
	a_mask_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(avs_write_in && !avs_waitrequest_out && widx == IDX_IRQ_MASK && avs_byteenable_in[0])
		|=> s_r.irq_mask == $past(avs_writedata_in[3:0]))
		else $error("interrupt mask not stored");

	// a cleared mask keeps the interrupt low
	a_irq_masked: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(s_r.irq_mask == 4'h0) |-> !irq_out)
		else $error("interrupt raised while masked");

	// main scenarios
	c_count_up: cover property (@(posedge clock_in) disable iff (!nrst_in) step_c[0] && up_c[0]);
	c_dir_inv: cover property (@(posedge clock_in) disable iff (!nrst_in) step_c[0] && s_r.dir_inv);
	c_ref_clear: cover property (@(posedge clock_in) disable iff (!nrst_in) clr_c[0]);
	c_flag_read: cover property (@(posedge clock_in) disable iff (!nrst_in)
		done_c && avs_read_in && widx == IDX_FLAG && s_r.flag != '0);
	c_irq: cover property (@(posedge clock_in) disable iff (!nrst_in) irq_out);

endmodule : quad_encoder_counter

// File: testbench/qec_enc_model.sv
// encoder, index and reference initiator model that drives the counter pins
`timescale 1ns/1ns
module qec_enc_model (
	input wire logic clock_in, // bench clock
	output logic [3:0] a_out, // encoder track a
	output logic [3:0] b_out, // encoder track b
	output logic [3:0] index_out, // index track
	output logic [3:0] ref_out // reference initiator
);
	// all tracks idle low at start
	initial begin
		a_out = 4'h0;
		b_out = 4'h0;
		index_out = 4'h0;
		ref_out = 4'h0;
	end
	task automatic step(input int ch, input logic up);
		@(posedge clock_in);
		// gray order 00,01,11,10 counts up
		if ((a_out[ch] == b_out[ch]) == up) b_out[ch] <= ~b_out[ch];
		else a_out[ch] <= ~a_out[ch];
		repeat (4) @(posedge clock_in);
	endtask : step
	task automatic jump(input int ch);
		@(posedge clock_in);
		a_out[ch] <= ~a_out[ch];
		b_out[ch] <= ~b_out[ch];
		repeat (4) @(posedge clock_in);
	endtask : jump
	task automatic pins(input logic [3:0] r, input logic [3:0] i);
		@(posedge clock_in);
		ref_out <= r;
		index_out <= i;
		repeat (4) @(posedge clock_in);
	endtask : pins
endmodule : qec_enc_model

// File: testbench/quad_encoder_counter_test.sv
// self-checking bench for the quadrature counter block
`timescale 1ns/1ns
module quad_encoder_counter_test;
	import qec_pkg::*;
	logic clock_in = 1'b0, nrst_in = 1'b0, rd = 1'b0, wr = 1'b0, irq, wait_r; // bus and clock
	logic [5:0] adr = 6'h00; // byte address
	logic [31:0] wd = 32'h0000_0000, rdat, q; // write data, read data, captured word
	logic [3:0] ea, eb, ei, er, ren_n = 4'hE, sel = 4'hA, addr_o, iled, rled; // pins
	int num_errors = 0, n_checks = 0; // counters
	always #10 clock_in = ~clock_in;
	qec_enc_model enc (.clock_in(clock_in), .a_out(ea), .b_out(eb), .index_out(ei), .ref_out(er));
	quad_encoder_counter dut (.clock_in(clock_in), .nrst_in(nrst_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wait_r), .enc_a_in(ea), .enc_b_in(eb),
		.enc_index_in(ei), .ref_in(er), .nreference_reset_enable_in(ren_n), .address_selector_in(sel),
		.address_out(addr_o), .index_led_out(iled), .ref_led_out(rled), .irq_out(irq));
	// compare one value
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one avalon transfer, held until waitrequest is low at the sampling edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= d;
		// look at the settled waitrequest between edges, act only on the next rising edge
		do begin
			@(negedge clock_in);
			n++;
		end while (wait_r !== 1'b0 && n < 20);
		if (n >= 20) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
		// the edge at which waitrequest is low: take read data, then release
		@(posedge clock_in);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	// read and compare
	task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask : rchk
	// let registered outputs land
	task automatic settle;
		repeat (3) @(negedge clock_in);
	endtask : settle
	// print counts and verdict, end the run
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// watchdog, tests need under two hundred cycles
	initial begin
		#400000;
		num_errors++;
		give_verdict();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clock_in);
		nrst_in <= 1'b1;
		rchk("count0", 6'h00, 32'h0000_0000);
		rchk("ctrl", 6'h10, 32'h0000_0000);
		rchk("unmapped", 6'h3C, 32'h0000_0000);
		$display("test reset done");
		repeat (3) enc.step(0, 1'b1);
		rchk("count0", 6'h00, 32'h0000_0003);
		repeat (2) enc.step(1, 1'b0);
		rchk("count1", 6'h04, 32'h00FF_FFFE);
		bus(1'b1, 6'h10, 32'h0000_0001);
		enc.step(0, 1'b1);
		rchk("count0", 6'h00, 32'h0000_0002);
		bus(1'b1, 6'h10, 32'h0000_0000);
		enc.jump(2);
		rchk("count2", 6'h08, 32'h0000_0000);
		$display("test counting done");
		bus(1'b1, 6'h1C, 32'h0000_0000);
		enc.pins(4'h3, 4'h3);
		chk("ref_led", 32'h0000_0003, 32'(rled));
		chk("index_led", 32'h0000_0003, 32'(iled));
		enc.pins(4'h0, 4'h0);
		rchk("count0", 6'h00, 32'h0000_0000);
		rchk("count1", 6'h04, 32'h00FF_FFFE);
		chk("irq masked", 32'h0000_0000, 32'(irq));
		bus(1'b1, 6'h1C, 32'h0000_000F);
		settle();
		chk("irq", 32'h0000_0001, 32'(irq));
		rchk("flag", 6'h14, 32'h0000_0001);
		rchk("flag again", 6'h14, 32'h0000_0000);
		rchk("irq status", 6'h18, 32'h0000_0001);
		bus(1'b1, 6'h18, 32'h0000_0001);
		settle();
		chk("irq cleared", 32'h0000_0000, 32'(irq));
		$display("test reference clear done");
		rchk("info", 6'h20, 32'h0000_00EA);
		chk("address", 32'h0000_000A, 32'(addr_o));
		$display("test address done");
		give_verdict();
	end
endmodule : quad_encoder_counter_test
